// *** otp_store_pkg.sv ***
// constants for the one-time-programmable motion parameter store
package otp_store_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned NUM_BYTES = 8;
  localparam logic [2:0] A_CLOCK_CURRENT_TRIM = 3'h0;
  localparam logic [2:0] A_THERMAL_BANDGAP_TRIM = 3'h1;
  localparam logic [2:0] A_NODE_ID = 3'h2;
  localparam logic [2:0] A_COIL_CURRENT = 3'h3;
  localparam logic [2:0] A_VELOCITY_LIMITS = 3'h4;
  localparam logic [2:0] A_FALLBACK_HIGH_DIR_RAMP = 3'h5;
  localparam logic [2:0] A_FALLBACK_LOW = 3'h6;
  localparam logic [2:0] A_STEPPING_LOCK = 3'h7;
  // lock bit positions in the stepping/lock byte
  localparam int unsigned GLOBAL_LOCK_POS = 0;
  localparam int unsigned FACTORY_LOCK_POS = 1;
  // last byte covered by the factory lock
  localparam logic [2:0] FACTORY_LOCK_LAST = 3'h1;
  // fallback value that disables the secure move
  localparam logic [10:0] FALLBACK_DISABLED = 11'h400;
  // unburned bit value
  localparam logic [7:0] BLANK_BYTE = 8'h00;
  // cell contents at delivery: trims (values arbitrary) and factory lock
  localparam logic [7:0] DELIVERED_CLOCK_CURRENT_TRIM = 8'h5a;
  localparam logic [7:0] DELIVERED_THERMAL_BANDGAP_TRIM = 8'h36;
  localparam logic [7:0] DELIVERED_STEPPING_LOCK = 8'h02;
  // burn pulse length
  localparam int unsigned BURN_TIME_US = 100;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned BURN_CYCLES = BURN_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W = 12;
  // step resolution codes
  localparam logic [1:0] STEP_HALF = 2'h0;
  localparam logic [1:0] STEP_QUARTER = 2'h1;
  localparam logic [1:0] STEP_EIGHTH = 2'h2;
  localparam logic [1:0] STEP_SIXTEENTH = 2'h3;
endpackage

// *** otp_motion_parameter_store.sv ***
// otp parameter store with burn/read commands and working ram copy
// Contract
// - blank bits read zero; burning sets a bit to one forever.
// - bits already at one are never burned again.
// - one burn command burns the supplied one-bits of one byte.
// - global lock blocks burning of bytes 0x00 to 0x07.
// - factory lock blocks burning of the two calibration bytes.
// - operating copy loads from the store at power-up; restore defaults reloads all but the node bits.
// - ram overrides all parameters except the four node bits.
// - seven-bit bus address joins node bits and wired pin state.
// - run current code picks one of sixteen levels, 59 to 800 ma.
// - standstill drops current to the hold code level.
// - resolution 00 half, 01 quarter, 10 eighth, 11 sixteenth.
// - direction bit ignored while continuous speed mode runs.
// - wired pin loss drives to fallback unless code is 0x400.
// - fallback is 11 msbs of position, low bits zero.
// - ramp code selects sixteen rates, 49 to 40047 full steps/s2.
// - restore defaults reloads ram, positions untouched.
`timescale 1ns/100ps
module otp_motion_parameter_store #(
  parameter int unsigned BURN_CYCLES = otp_store_pkg::BURN_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  // power-up strobe: copy store to operating and ram parameters
  input wire logic power_up_load,
  // burn command
  input wire logic cmd_burn_byte,
  input wire logic [2:0] burn_addr,
  input wire logic [7:0] burn_data,
  output logic burn_busy,
  output logic burn_done,
  output logic burn_refused,
  // read-back command
  input wire logic cmd_read_burned_byte,
  input wire logic [2:0] read_addr,
  output logic [7:0] read_data,
  output logic read_valid,
  // ram override and restore
  input wire logic cmd_load_motion_settings,
  input wire logic [7:0] ram_coil_current,
  input wire logic [7:0] ram_velocity_limits,
  input wire logic [7:0] ram_fallback_high_dir_ramp,
  input wire logic [7:0] ram_fallback_low,
  input wire logic [1:0] ram_microstep_resolution,
  input wire logic cmd_restore_defaults,
  // motion context
  input wire logic wired_address_pin,
  input wire logic wired_pin_lost,
  input wire logic motor_standstill,
  input wire logic continuous_speed_mode,
  // decoded outputs
  output logic [6:0] bus_address,
  output logic [9:0] coil_current_ma,
  output logic [1:0] microstep_resolution,
  output logic [4:0] microsteps_per_full,
  output logic rotate_ccw,
  output logic [15:0] fallback_target,
  output logic fallback_move,
  output logic [15:0] ramp_rate,
  output logic ramp_speed_limited,
  output logic [9:0] max_speed,
  output logic [3:0] min_speed_factor,
  output logic global_lock_bit,
  output logic factory_lock_bit
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BURN = 2'b01,
    ST_DONE = 2'b11
  } burn_state_t;

  typedef struct packed {
    logic [7:0][7:0] fuse;
    logic [3:0] node_bits;
    logic [7:0] coil;
    logic [7:0] vel;
    logic [7:0] fb_hi;
    logic [7:0] fb_lo;
    logic [1:0] step;
    burn_state_t st;
    logic [2:0] addr;
    logic [7:0] mask;
    logic [11:0] cnt;
    logic done;
    logic refused;
    logic [7:0] rdata;
    logic rvalid;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic locked;
  logic [7:0] new_bits;

  // current table shared by run and hold codes
  function automatic logic [9:0] current_ma(input logic [3:0] code);
    logic [9:0] t [16];
    t = '{10'd59, 10'd71, 10'd84, 10'd100, 10'd119, 10'd141, 10'd168,
          10'd200, 10'd238, 10'd283, 10'd336, 10'd400, 10'd476, 10'd566,
          10'd673, 10'd800};
    return t[code];
  endfunction

  function automatic logic [15:0] ramp_of(input logic [3:0] code);
    logic [15:0] t [16];
    t = '{16'd49, 16'd218, 16'd1004, 16'd3609, 16'd6228, 16'd8848,
          16'd11409, 16'd13970, 16'd16531, 16'd19092, 16'd21886,
          16'd24447, 16'd27008, 16'd29570, 16'd34925, 16'd40047};
    return t[code];
  endfunction

  function automatic logic [9:0] vmax_of(input logic [3:0] code);
    logic [9:0] t [16];
    t = '{10'd99, 10'd136, 10'd167, 10'd197, 10'd213, 10'd228, 10'd243,
          10'd273, 10'd303, 10'd334, 10'd364, 10'd395, 10'd456, 10'd546,
          10'd729, 10'd973};
    return t[code];
  endfunction

  // lock decode uses the live store so a lock burn takes effect at once
  always_comb begin
    locked = s_q.fuse[otp_store_pkg::A_STEPPING_LOCK]
               [otp_store_pkg::GLOBAL_LOCK_POS];
    if (s_q.fuse[otp_store_pkg::A_STEPPING_LOCK]
          [otp_store_pkg::FACTORY_LOCK_POS] &&
        burn_addr <= otp_store_pkg::FACTORY_LOCK_LAST) begin
      locked = 1'b1;
    end
    new_bits = burn_data & ~s_q.fuse[burn_addr];
  end

  // next state: burn sequencer, read-back, ram copy
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.refused = 1'b0;
    s_d.rvalid = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (cmd_burn_byte) begin
          if (locked) begin
            s_d.refused = 1'b1;
          end else begin
            s_d.addr = burn_addr;
            s_d.mask = new_bits;
            s_d.cnt = '0;
            s_d.st = ST_BURN;
          end
        end
      end
      ST_BURN: begin
        if (s_q.cnt == 12'(BURN_CYCLES - 1)) begin
          // only ones are or-ed in; nothing clears a fuse
          s_d.fuse[s_q.addr] = s_q.fuse[s_q.addr] | s_q.mask;
          s_d.st = ST_DONE;
        end else begin
          s_d.cnt = s_q.cnt + 12'h001;
        end
      end
      ST_DONE: begin
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (cmd_read_burned_byte) begin
      s_d.rdata = s_q.fuse[read_addr];
      s_d.rvalid = 1'b1;
    end
    // store copied to operating set at power-up and on restore; restore skips node
    if (power_up_load || cmd_restore_defaults) begin
      s_d.coil = s_q.fuse[otp_store_pkg::A_COIL_CURRENT];
      s_d.vel = s_q.fuse[otp_store_pkg::A_VELOCITY_LIMITS];
      s_d.fb_hi = s_q.fuse[otp_store_pkg::A_FALLBACK_HIGH_DIR_RAMP];
      s_d.fb_lo = s_q.fuse[otp_store_pkg::A_FALLBACK_LOW];
      s_d.step = s_q.fuse[otp_store_pkg::A_STEPPING_LOCK][3:2];
    end else if (cmd_load_motion_settings) begin
      s_d.coil = ram_coil_current;
      s_d.vel = ram_velocity_limits;
      s_d.fb_hi = ram_fallback_high_dir_ramp;
      s_d.fb_lo = ram_fallback_low;
      s_d.step = ram_microstep_resolution;
    end
    if (power_up_load) begin
      s_d.node_bits = s_q.fuse[otp_store_pkg::A_NODE_ID][3:0];
    end
  end

  // reset stands for delivery: the cells own no start value, so reset
  // lays down the factory image; power_up_load is the power cycle and
  // keeps every burn, but a mid-run reset forgets application burns
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.fuse[otp_store_pkg::A_CLOCK_CURRENT_TRIM] <=
        otp_store_pkg::DELIVERED_CLOCK_CURRENT_TRIM;
      s_q.fuse[otp_store_pkg::A_THERMAL_BANDGAP_TRIM] <=
        otp_store_pkg::DELIVERED_THERMAL_BANDGAP_TRIM;
      s_q.fuse[otp_store_pkg::A_STEPPING_LOCK] <=
        otp_store_pkg::DELIVERED_STEPPING_LOCK;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs decoded from the operating copy, the burn sequencer and the store lock bits
  always_comb begin
    burn_busy = s_q.st != ST_IDLE;
    burn_done = s_q.done;
    burn_refused = s_q.refused;
    read_data = s_q.rdata;
    read_valid = s_q.rvalid;
    bus_address = {2'b11, s_q.node_bits, wired_address_pin};
    coil_current_ma = motor_standstill ? current_ma(s_q.coil[3:0])
                                       : current_ma(s_q.coil[7:4]);
    microstep_resolution = s_q.step;
    unique case (s_q.step)
      otp_store_pkg::STEP_HALF: microsteps_per_full = 5'd2;
      otp_store_pkg::STEP_QUARTER: microsteps_per_full = 5'd4;
      otp_store_pkg::STEP_EIGHTH: microsteps_per_full = 5'd8;
      otp_store_pkg::STEP_SIXTEENTH: microsteps_per_full = 5'd16;
    endcase
    rotate_ccw = continuous_speed_mode ? 1'b0 : s_q.fb_hi[4];
    fallback_target = {s_q.fb_hi[7:5], s_q.fb_lo, 5'h00};
    fallback_move = wired_pin_lost &&
      ({s_q.fb_hi[7:5], s_q.fb_lo} != otp_store_pkg::FALLBACK_DISABLED);
    ramp_rate = ramp_of(s_q.fb_hi[3:0]);
    ramp_speed_limited = s_q.fb_hi[3:0] <= 4'h1 || s_q.fb_hi[3:0] >= 4'h9;
    max_speed = vmax_of(s_q.vel[7:4]);
    min_speed_factor = s_q.vel[3:0];
    global_lock_bit = s_q.fuse[otp_store_pkg::A_STEPPING_LOCK][0];
    factory_lock_bit = s_q.fuse[otp_store_pkg::A_STEPPING_LOCK][1];
  end

  property p_locked_refused;
    @(posedge clk) disable iff (!reset_n)
      (cmd_burn_byte && !burn_busy && locked) |=> burn_refused;
  endproperty
  a_locked_refused: assert property (p_locked_refused)
    else $error("locked burn not refused");

  property p_no_clear;
    @(posedge clk) disable iff (!reset_n)
      ##1 ((s_q.fuse & $past(s_q.fuse)) == $past(s_q.fuse));
  endproperty
  a_no_clear: assert property (p_no_clear)
    else $error("a burned bit went back to zero");

  property p_burn_len;
    @(posedge clk) disable iff (!reset_n)
      (s_q.st == ST_IDLE && cmd_burn_byte && !locked) |=>
        burn_busy ##1 (!burn_done)[*1];
  endproperty
  a_burn_len: assert property (p_burn_len)
    else $error("burn did not start");

  property p_node_stable;
    @(posedge clk) disable iff (!reset_n)
      !power_up_load |=> $stable(s_q.node_bits);
  endproperty
  a_node_stable: assert property (p_node_stable)
    else $error("node bits changed without power-up");

  property p_fallback;
    @(posedge clk) disable iff (!reset_n)
      (wired_pin_lost && {s_q.fb_hi[7:5], s_q.fb_lo} == 11'h400)
        |-> !fallback_move;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("fallback move with disabled code");

  property p_addr;
    @(posedge clk) disable iff (!reset_n)
      bus_address[4:1] == s_q.node_bits && bus_address[0] == wired_address_pin;
  endproperty
  a_addr: assert property (p_addr)
    else $error("bus address mismatch");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
      motor_standstill |-> coil_current_ma == current_ma(s_q.coil[3:0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold current not applied");

  property p_dir;
    @(posedge clk) disable iff (!reset_n)
      continuous_speed_mode |-> !rotate_ccw;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction used in continuous mode");

  property p_mask_fresh;
    @(posedge clk) disable iff (!reset_n)
      (s_q.st == ST_IDLE && cmd_burn_byte && !locked) |=>
        ((s_q.mask & s_q.fuse[s_q.addr]) == 8'h00);
  endproperty
  a_mask_fresh: assert property (p_mask_fresh)
    else $error("burn mask holds a bit already burned");

  property p_burn_addr;
    @(posedge clk) disable iff (!reset_n)
      (s_q.st == ST_IDLE && cmd_burn_byte && !locked) |=>
        (s_q.addr == $past(burn_addr));
  endproperty
  a_burn_addr: assert property (p_burn_addr)
    else $error("burn aimed at the wrong byte");

  property p_done_pulse;
    @(posedge clk) disable iff (!reset_n)
      burn_done |=> (!burn_done && !burn_busy);
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("burn done not a single pulse");

  property p_global_lock;
    @(posedge clk) disable iff (!reset_n)
      (cmd_burn_byte && !burn_busy && global_lock_bit) |=> burn_refused;
  endproperty
  a_global_lock: assert property (p_global_lock)
    else $error("burn accepted under global lock");

  property p_factory_lock;
    @(posedge clk) disable iff (!reset_n)
      (cmd_burn_byte && !burn_busy && factory_lock_bit &&
        burn_addr <= otp_store_pkg::FACTORY_LOCK_LAST) |=> burn_refused;
  endproperty
  a_factory_lock: assert property (p_factory_lock)
    else $error("trim byte burn accepted under factory lock");

  property p_refused_keeps;
    @(posedge clk) disable iff (!reset_n)
      burn_refused |-> $stable(s_q.fuse);
  endproperty
  a_refused_keeps: assert property (p_refused_keeps)
    else $error("refused burn changed the store");

  property p_step_decode;
    @(posedge clk) disable iff (!reset_n)
      microsteps_per_full == (5'd2 << microstep_resolution);
  endproperty
  a_step_decode: assert property (p_step_decode)
    else $error("microstep count does not match resolution");

  property p_fallback_lsb;
    @(posedge clk) disable iff (!reset_n)
      fallback_target[4:0] == 5'h00;
  endproperty
  a_fallback_lsb: assert property (p_fallback_lsb)
    else $error("fallback low position bits not zero");

endmodule

// *** host_model.sv ***
// host side model issuing burn and read-back commands
`timescale 1ns/100ps
module host_model #(
  parameter int unsigned WAIT_MAX = 64
) (
  input wire logic clk,
  output logic cmd_burn_byte,
  output logic [2:0] burn_addr,
  output logic [7:0] burn_data,
  input wire logic burn_done,
  input wire logic burn_refused,
  output logic cmd_read_burned_byte,
  output logic [2:0] read_addr,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  // idle levels before the first request
  initial begin
    cmd_burn_byte = 1'b0;
    burn_addr = 3'h0;
    burn_data = 8'h00;
    cmd_read_burned_byte = 1'b0;
    read_addr = 3'h0;
  end

  // read request held one edge, data taken with the valid pulse
  task automatic read(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_read_burned_byte <= 1'b1;
    read_addr <= a;
    @(posedge clk);
    cmd_read_burned_byte <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (read_valid !== 1'b1 && n < WAIT_MAX);
    // a read that never answers hands back unknowns so the check fails
    d = (read_valid === 1'b1) ? read_data : 8'hxx;
  endtask

  // one byte per command, then always read it back
  task automatic burn(input logic [2:0] a, input logic [7:0] d,
                      output logic rf, output logic [7:0] bk);
    int n;
    n = 0;
    @(posedge clk);
    cmd_burn_byte <= 1'b1;
    burn_addr <= a;
    burn_data <= d;
    @(posedge clk);
    cmd_burn_byte <= 1'b0;
    // released data must not look valid
    burn_data <= ~d;
    do begin
      @(posedge clk);
      n++;
    end while (burn_done !== 1'b1 && burn_refused !== 1'b1 && n < WAIT_MAX);
    rf = (burn_done === 1'b1 || burn_refused === 1'b1) ? burn_refused : 1'bx;
    read(a, bk);
  endtask
endmodule

// *** otp_motion_parameter_store_tb.sv ***
// self-checking bench for the otp motion parameter store
`timescale 1ns/100ps
module otp_motion_parameter_store_tb;
  typedef struct packed {
    logic [3:0] ctx;
    logic [9:0] ma;
    logic ccw;
    logic [6:0] adr;
    logic move;
  } row_t;
  logic clk = 1'b0, reset_n = 1'b0, power_up_load = 1'b0;
  logic cmd_load_motion_settings = 1'b0, cmd_restore_defaults = 1'b0;
  logic [7:0] ram_coil_current = 8'h00, ram_velocity_limits = 8'h00;
  logic [7:0] ram_fallback_high_dir_ramp = 8'h00, ram_fallback_low = 8'h00;
  logic [1:0] ram_microstep_resolution = 2'h0;
  logic wired_address_pin = 1'b0, wired_pin_lost = 1'b0;
  logic motor_standstill = 1'b0, continuous_speed_mode = 1'b0;
  logic cmd_burn_byte, cmd_read_burned_byte, burn_busy, burn_done;
  logic burn_refused, read_valid, rotate_ccw, fallback_move;
  logic ramp_speed_limited, global_lock_bit, factory_lock_bit;
  logic [2:0] burn_addr, read_addr;
  logic [7:0] burn_data, read_data, b;
  logic [6:0] bus_address;
  logic [9:0] coil_current_ma, max_speed;
  logic [1:0] microstep_resolution;
  logic [4:0] microsteps_per_full;
  logic [15:0] fallback_target, ramp_rate;
  logic [3:0] min_speed_factor;
  int miscompares = 0, checked = 0;
  int ma [16] = '{59, 71, 84, 100, 119, 141, 168, 200, 238, 283, 336, 400,
                  476, 566, 673, 800};
  int vx [16] = '{99, 136, 167, 197, 213, 228, 243, 273, 303, 334, 364, 395,
                  456, 546, 729, 973};
  int ac [16] = '{49, 218, 1004, 3609, 6228, 8848, 11409, 13970, 16531,
                  19092, 21886, 24447, 27008, 29570, 34925, 40047};
  logic [7:0] fac [8] = '{otp_store_pkg::DELIVERED_CLOCK_CURRENT_TRIM,
                          otp_store_pkg::DELIVERED_THERMAL_BANDGAP_TRIM,
                          8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          otp_store_pkg::DELIVERED_STEPPING_LOCK};
  row_t rows [3] = '{'{4'h0, 10'd400, 1'b1, 7'h6a, 1'b0},
                     '{4'hb, 10'd800, 1'b1, 7'h6b, 1'b0},
                     '{4'h4, 10'd400, 1'b0, 7'h6a, 1'b0}};

  // short burn count keeps the run brief
  otp_motion_parameter_store #(.BURN_CYCLES(4)) u_otp_motion_parameter_store (
    .clk, .reset_n, .power_up_load, .cmd_burn_byte, .burn_addr, .burn_data,
    .burn_busy, .burn_done, .burn_refused, .cmd_read_burned_byte, .read_addr,
    .read_data, .read_valid, .cmd_load_motion_settings, .ram_coil_current,
    .ram_velocity_limits, .ram_fallback_high_dir_ramp, .ram_fallback_low,
    .ram_microstep_resolution, .cmd_restore_defaults, .wired_address_pin,
    .wired_pin_lost, .motor_standstill, .continuous_speed_mode, .bus_address,
    .coil_current_ma, .microstep_resolution, .microsteps_per_full,
    .rotate_ccw, .fallback_target, .fallback_move, .ramp_rate,
    .ramp_speed_limited, .max_speed, .min_speed_factor, .global_lock_bit,
    .factory_lock_bit);
  host_model u_host_model (.clk, .cmd_burn_byte, .burn_addr, .burn_data,
    .burn_done, .burn_refused, .cmd_read_burned_byte, .read_addr,
    .read_data, .read_valid);

  // clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bc(input logic [2:0] a, input logic [7:0] d,
                    input logic r, input logic [7:0] e);
    logic rf;
    logic [7:0] bk;
    u_host_model.burn(a, d, rf, bk);
    check(16'(rf), 16'(r));
    check(16'(bk), 16'(e));
    check(16'(burn_busy), 16'h0000);
  endtask

  // k: 0 power-up copy, 1 ram load, 2 restore defaults
  task automatic strobe(input int k);
    @(posedge clk);
    power_up_load <= (k == 0);
    cmd_load_motion_settings <= (k == 1);
    cmd_restore_defaults <= (k == 2);
    @(posedge clk);
    {power_up_load, cmd_load_motion_settings, cmd_restore_defaults} <= 3'h0;
    @(posedge clk);
    #1;
  endtask

  task automatic ctx(input logic [3:0] c);
    @(posedge clk);
    {motor_standstill, continuous_speed_mode, wired_address_pin,
     wired_pin_lost} <= c;
    @(posedge clk);
    #1;
  endtask

  // a hung handshake would otherwise stall the run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    strobe(0);
    for (int i = 0; i < 8; i++) begin
      u_host_model.read(3'(i), b);
      check(16'(b), 16'(fac[i]));
    end
    bc(3'h3, 8'hb4, 1'b0, 8'hb4);
    bc(3'h3, 8'h1b, 1'b0, 8'hbf);
    bc(3'h4, 8'h32, 1'b0, 8'h32);
    bc(3'h5, 8'h99, 1'b0, 8'h99);
    bc(3'h7, 8'h0c, 1'b0, 8'h0e);
    // node bits go last: the address may move, so a power cycle follows
    bc(3'h2, 8'h05, 1'b0, 8'h05);
    // burned bits stay inert until the next power-up copy
    check(16'(coil_current_ma), 16'd59);
    check(16'(bus_address), 16'h0060);
    strobe(0);
    for (int i = 0; i < 3; i++) begin
      ctx(rows[i].ctx);
      check(16'(coil_current_ma), 16'(rows[i].ma));
      check(16'(rotate_ccw), 16'(rows[i].ccw));
      check(16'(bus_address), 16'(rows[i].adr));
      check(16'(fallback_move), 16'(rows[i].move));
    end
    check(16'(microsteps_per_full), 16'd16);
    check(ramp_rate, 16'd19092);
    check(16'(ramp_speed_limited), 16'h1);
    check(16'(max_speed), 16'd197);
    check(16'(min_speed_factor), 16'h2);
    check(fallback_target, 16'h8000);
    ctx(4'h0);
    // every code of the current, speed, ramp and step fields through the ram override path
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      ram_coil_current <= {4'(i), ~4'(i)};
      ram_velocity_limits <= {4'(i), 4'(i)};
      ram_fallback_high_dir_ramp <= {3'(i), 1'b0, 4'(i)};
      ram_fallback_low <= 8'(i * 3);
      ram_microstep_resolution <= 2'(i);
      strobe(1);
      check(16'(coil_current_ma), 16'(ma[i]));
      check(16'(max_speed), 16'(vx[i]));
      check(16'(min_speed_factor), 16'(i));
      check(ramp_rate, 16'(ac[i]));
      check(16'(ramp_speed_limited), 16'(i < 2 || i > 8));
      check(16'(microsteps_per_full), 16'(2 << (i % 4)));
      check(16'(microstep_resolution), 16'(i % 4));
      check(fallback_target, {3'(i), 8'(i * 3), 5'h00});
      ctx(4'h8);
      check(16'(coil_current_ma), 16'(ma[15 - i]));
      ctx(4'h0);
    end
    ctx(4'h1);
    check(16'(fallback_move), 16'h1);
    check(16'(bus_address), 16'h006a);
    ctx(4'h0);
    strobe(2);
    check(16'(coil_current_ma), 16'd400);
    check(ramp_rate, 16'd19092);
    bc(3'h7, 8'h02, 1'b0, 8'h0e);
    check(16'(factory_lock_bit), 16'h1);
    bc(3'h0, 8'h11, 1'b1, fac[0]);
    bc(3'h1, 8'h11, 1'b1, fac[1]);
    bc(3'h4, 8'h0c, 1'b0, 8'h3e);
    bc(3'h7, 8'h01, 1'b0, 8'h0f);
    check(16'(global_lock_bit), 16'h1);
    bc(3'h4, 8'hc0, 1'b1, 8'h3e);
    bc(3'h6, 8'hff, 1'b1, 8'h00);
    finish_test();
  end
endmodule
